/* include/charge_time_pkg.sv */
package charge_time_pkg;
	// register byte addresses on the APB bus
	localparam logic [11:0] ADDR_CONTROL      = 12'h000;
	localparam logic [11:0] ADDR_EDGE_CONTROL = 12'h004;
	localparam logic [11:0] ADDR_CURRENT      = 12'h008;

	// control register fields
	localparam int CTL_UNIT_ENABLE   = 15;
	localparam int CTL_EDGE_GATE     = 11;
	localparam int CTL_ORDER_ENFORCE = 10;
	localparam int CTL_TRIGGER_EN    = 8;
	localparam logic [15:0] CTL_MASK = 16'h8D00;

	// edge control fields
	localparam int EC_CH1_SAMPLING = 15;
	localparam int EC_CH1_POLARITY = 14;
	localparam int EC_CH1_SRC_HI   = 13;
	localparam int EC_CH1_SRC_LO   = 10;
	localparam int EC_CH2_FLAG     = 9;
	localparam int EC_CH1_FLAG     = 8;
	localparam int EC_CH2_SAMPLING = 7;
	localparam int EC_CH2_POLARITY = 6;
	localparam int EC_CH2_SRC_HI   = 5;
	localparam int EC_CH2_SRC_LO   = 2;
	localparam logic [15:0] EC_MASK = 16'hFFFC;

	// current source fields
	localparam int CS_TRIM_HI  = 15;
	localparam int CS_TRIM_LO  = 10;
	localparam int CS_RANGE_HI = 9;
	localparam int CS_RANGE_LO = 8;
	localparam logic [15:0] CS_MASK = 16'hFF00;

	localparam logic [15:0] RESET_VALUE = 16'h0000;

	// source selector codes
	localparam logic [3:0] SRC_CH1_TIMER   = 4'h0;
	localparam logic [3:0] SRC_CH1_COMPARE = 4'h1;
	localparam logic [3:0] SRC_CH1_PIN_B   = 4'h2;
	localparam logic [3:0] SRC_CH1_PIN_A   = 4'h3;
	localparam logic [3:0] SRC_CH2_CAPTURE = 4'h0;
	localparam logic [3:0] SRC_CH2_COMPAR2 = 4'h1;
	localparam logic [3:0] SRC_CH2_PIN_A   = 4'h2;
	localparam logic [3:0] SRC_CH2_PIN_B   = 4'h3;

	// current range codes
	localparam logic [1:0] RANGE_RESERVED = 2'h0;
	localparam logic [1:0] RANGE_BASE     = 2'h1;
	localparam logic [1:0] RANGE_TEN      = 2'h2;
	localparam logic [1:0] RANGE_HUNDRED  = 2'h3;
endpackage

/* core/charge_time_edge_control.sv */
// Notes on behaviour
// - channel one sampling bit: edge or level
// - channel one polarity bit: rising or falling
// - channel one source selector codes
// - channel two flag set by event, writable
// - channel one flag set by event, writable
// - channel two sampling bit: edge or level
// - channel two polarity bit: rising or falling
// - channel two source selector codes
// - two lowest edge bits read zero
// - six-bit signed trim in two percent steps
// - range codes: base, ten, hundred times
// - unit runs only while enabled
// - edge gate blocks events when clear
// - order enforce: channel one before two
// - trigger output only while enabled
//
// Design decisions made here: the register offsets and the APB slave port.
`timescale 1ns/10ps
`default_nettype none
module charge_time_edge_control
	import charge_time_pkg::*;
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	// edge sources
	input  wire logic        timerOut,
	input  wire logic        compareOutputOne,
	input  wire logic        captureInputOne,
	input  wire logic        comparatorTwo,
	input  wire logic        externalEdgePinA,
	input  wire logic        externalEdgePinB,
	// analog side
	output logic             currentSourceOn,
	output logic [5:0]       currentTrim,
	output logic [1:0]       currentRange,
	output logic             triggerOut
);
	import charge_time_pkg::*;

	logic [15:0] ctl_q, ctl_d;
	logic [15:0] edge_q, edge_d;
	logic [15:0] cur_q, cur_d;
	logic [1:0]  prevIn_q, prevIn_d;
	logic [31:0] prdata_q, prdata_d;
	logic        pslverr_q, pslverr_d;
	logic        pready_q, pready_d;
	logic        srcOn_q, srcOn_d;
	logic        trig_q, trig_d;

	logic [1:0] rawIn;
	logic [1:0] hit;
	logic       access, done;

	// channel one source mux
	// channel one selection
	function automatic logic selectOne(input logic [3:0] code,
		input logic tmr, input logic cmp, input logic pa, input logic pb);
		logic v;
		v = 1'b0;
		unique case (code)
			SRC_CH1_TIMER:   v = tmr;
			SRC_CH1_COMPARE: v = cmp;
			SRC_CH1_PIN_B:   v = pb;
			SRC_CH1_PIN_A:   v = pa;
			default:         v = 1'b0;
		endcase
		return v;
	endfunction

	function automatic logic selectTwo(input logic [3:0] code,
		input logic cap, input logic cmp, input logic pa, input logic pb);
		logic v;
		v = 1'b0;
		unique case (code)
			SRC_CH2_CAPTURE: v = cap;
			SRC_CH2_COMPAR2: v = cmp;
			SRC_CH2_PIN_A:   v = pa;
			SRC_CH2_PIN_B:   v = pb;
			default:         v = 1'b0;
		endcase
		return v;
	endfunction

	// edge or level detect with polarity
	function automatic logic detect(input logic now, input logic prev,
		input logic edgeMode, input logic rising);
		logic act, pact;
		act = rising ? now : ~now;
		pact = rising ? prev : ~prev;
		return edgeMode ? (act & ~pact) : act;
	endfunction

	assign access = psel & penable & ~pready_q;
	// writes land at the edge where the master sees pready high
	assign done = psel & penable & pready_q;

	always_comb
	begin
		rawIn[0] = selectOne(edge_q[EC_CH1_SRC_HI:EC_CH1_SRC_LO], timerOut,
			compareOutputOne, externalEdgePinA, externalEdgePinB);
		rawIn[1] = selectTwo(edge_q[EC_CH2_SRC_HI:EC_CH2_SRC_LO],
			captureInputOne, comparatorTwo, externalEdgePinA,
			externalEdgePinB);
		hit[0] = detect(rawIn[0], prevIn_q[0], edge_q[EC_CH1_SAMPLING],
			edge_q[EC_CH1_POLARITY]);
		hit[1] = detect(rawIn[1], prevIn_q[1], edge_q[EC_CH2_SAMPLING],
			edge_q[EC_CH2_POLARITY]);
		if (!ctl_q[CTL_UNIT_ENABLE] || !ctl_q[CTL_EDGE_GATE])
		begin
			hit = 2'b00;
		end
		// channel two waits for channel one
		if (ctl_q[CTL_ORDER_ENFORCE] && !edge_q[EC_CH1_FLAG] && !hit[0])
		begin
			hit[1] = 1'b0;
		end
	end

	always_comb
	begin
		ctl_d = ctl_q;
		edge_d = edge_q;
		cur_d = cur_q;
		prdata_d = prdata_q;
		pslverr_d = 1'b0;
		pready_d = access;
		prevIn_d = rawIn;
		if (done && pwrite)
		begin
			unique case (paddr)
				ADDR_CONTROL:      ctl_d = pwdata[15:0] & CTL_MASK;
				ADDR_EDGE_CONTROL: edge_d = pwdata[15:0] & EC_MASK;
				// trim and range stored as written
				ADDR_CURRENT:      cur_d = pwdata[15:0] & CS_MASK;
				default:           cur_d = cur_q;
			endcase
		end
		if (access && pwrite)
		begin
			pslverr_d = (paddr != ADDR_CONTROL)
				&& (paddr != ADDR_EDGE_CONTROL)
				&& (paddr != ADDR_CURRENT);
		end
		else if (access)
		begin
			unique case (paddr)
				ADDR_CONTROL:      prdata_d = {16'h0000, ctl_q};
				ADDR_EDGE_CONTROL: prdata_d = {16'h0000, edge_q};
				ADDR_CURRENT:      prdata_d = {16'h0000, cur_q};
				default:
				begin
					prdata_d = 32'h0000_0000;
					pslverr_d = 1'b1;
				end
			endcase
		end
		// event sets flag, wins over write
		if (hit[0])
		begin
			edge_d[EC_CH1_FLAG] = 1'b1;
		end
		if (hit[1])
		begin
			edge_d[EC_CH2_FLAG] = 1'b1;
		end
		srcOn_d = ctl_q[CTL_UNIT_ENABLE]
			& (edge_q[EC_CH1_FLAG] ^ edge_q[EC_CH2_FLAG]);
		trig_d = ctl_q[CTL_UNIT_ENABLE] & ctl_q[CTL_TRIGGER_EN]
			& edge_q[EC_CH2_FLAG];
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			ctl_q <= RESET_VALUE;
			edge_q <= RESET_VALUE;
			cur_q <= RESET_VALUE;
			prevIn_q <= 2'h0;
			prdata_q <= 32'h0000_0000;
			pslverr_q <= 1'b0;
			pready_q <= 1'b0;
			srcOn_q <= 1'b0;
			trig_q <= 1'b0;
		end
		else
		begin
			ctl_q <= ctl_d;
			edge_q <= edge_d;
			cur_q <= cur_d;
			prevIn_q <= prevIn_d;
			prdata_q <= prdata_d;
			pslverr_q <= pslverr_d;
			pready_q <= pready_d;
			srcOn_q <= srcOn_d;
			trig_q <= trig_d;
		end
	end

	assign pready = pready_q;
	assign prdata = prdata_q;
	assign pslverr = pslverr_q;
	assign currentSourceOn = srcOn_q;
	assign currentTrim = cur_q[CS_TRIM_HI:CS_TRIM_LO];
	assign currentRange = cur_q[CS_RANGE_HI:CS_RANGE_LO];
	assign triggerOut = trig_q;
endmodule
`default_nettype wire

/* dv/edge_source_model.sv */
`timescale 1ns/10ps
`default_nettype none
module edge_source_model (
	// system side
	input  wire logic       clk,
	input  wire logic       rst,
	// {pinB, pinA, comparator, capture, compare, timer}
	input  wire logic [5:0] pattern,
	output var  logic [5:0] level
);
	// peripheral outputs move just after the system clock edge
	always_ff @(posedge clk or posedge rst)
		if (rst)
			level <= 6'h00;
		else
			level <= pattern;
endmodule
`default_nettype wire

/* dv/charge_time_edge_control_assertions.sv */
`timescale 1ns/10ps
`default_nettype none
module charge_time_edge_control_assertions (
	// clock, reset, bus
	input wire logic        clk,
	input wire logic        rst,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pready,
	input wire logic [31:0] prdata,
	input wire logic        pslverr,
	// analog side
	input wire logic        currentSourceOn,
	input wire logic [5:0]  currentTrim,
	input wire logic [1:0]  currentRange,
	input wire logic        triggerOut
);
	logic enQ;
	logic trigQ;
	// shadow of unit and trigger enables
	always_ff @(posedge clk or posedge rst)
		if (rst)
			{enQ, trigQ} <= 2'h0;
		else if (pready && pwrite && paddr == 12'h000)
			{enQ, trigQ} <= {pwdata[15], pwdata[8]};
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	AST_WAIT_STATE: assert property (psel && penable && !pready |=> pready)
		else $error("pready late");
	AST_READY_PULSE: assert property (pready |=> !pready)
		else $error("pready too long");
	AST_UNMAPPED: assert property (pready && paddr > 12'h008 |-> pslverr)
		else $error("no slave error");
	AST_PAD_ZERO: assert property (
		pready && !pwrite && paddr == 12'h004 |-> prdata[1:0] == 2'h0)
		else $error("low edge bits set");
	AST_TRIM: assert property (pready && pwrite && paddr == 12'h008
		|=> currentTrim == $past(pwdata[15:10]))
		else $error("trim wrong");
	AST_RANGE: assert property (pready && pwrite && paddr == 12'h008
		|=> currentRange == $past(pwdata[9:8]))
		else $error("range wrong");
	AST_UNIT_OFF: assert property (!enQ |=> !currentSourceOn)
		else $error("source on while disabled");
	AST_TRIG_OFF: assert property (!(enQ && trigQ) |=> !triggerOut)
		else $error("trigger while disabled");
endmodule
bind charge_time_edge_control charge_time_edge_control_assertions chk (
	.clk(clk), .rst(rst), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
	.prdata(prdata), .pslverr(pslverr), .currentSourceOn(currentSourceOn),
	.currentTrim(currentTrim), .currentRange(currentRange),
	.triggerOut(triggerOut));
`default_nettype wire

/* dv/charge_time_edge_control_bench.sv */
`timescale 1ns/10ps
`default_nettype none
module charge_time_edge_control_bench;
	import charge_time_pkg::*;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic        pready, pslverr, csOn, trigOut;
	logic [31:0] prdata, rd;
	logic [5:0]  pattern = 6'h00;
	logic [5:0]  src, trim;
	logic [1:0]  rng;
	int          failures = 0;
	int          testsRun = 0;
	// address, write data, expected read back
	logic [43:0] rows [5] = '{44'h004_FFFF_FFFC, 44'h008_FFFF_FF00,
		44'h008_0300_0300, 44'h00C_1234_0000, 44'h000_FFFF_8D00};
	always #20 clk = ~clk;
	charge_time_edge_control dut (.clk(clk), .rst(rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pready(pready), .prdata(prdata), .pslverr(pslverr),
		.timerOut(src[0]), .compareOutputOne(src[1]),
		.captureInputOne(src[2]), .comparatorTwo(src[3]),
		.externalEdgePinA(src[4]), .externalEdgePinB(src[5]),
		.currentSourceOn(csOn), .currentTrim(trim), .currentRange(rng),
		.triggerOut(trigOut));
	edge_source_model partner (.clk(clk), .rst(rst), .pattern(pattern),
		.level(src));
	task automatic xfer(input logic [11:0] a, input logic [15:0] d,
		input logic w);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		paddr <= a;
		pwdata <= {16'h0000, d};
		pwrite <= w;
		@(posedge clk);
		penable <= 1'b1;
		do
			@(posedge clk);
		while (pready !== 1'b1 && ++n < 20);
		if (pready !== 1'b1)
		begin
			failures++;
			give_verdict;
		end
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic chk(input string nm, input logic [31:0] seen, exp);
		testsRun++;
		if (seen !== exp)
		begin
			failures++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", testsRun, failures);
		if (failures == 0 && testsRun > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial
	begin
		#100000;
		failures++;
		give_verdict;
	end
	initial
	begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		xfer(ADDR_EDGE_CONTROL, 16'h0000, 1'b0);
		chk("edge reset", rd, 32'h0);
		foreach (rows[i])
		begin
			xfer(rows[i][43:32], rows[i][31:16], 1'b1);
			xfer(rows[i][43:32], 16'h0000, 1'b0);
			chk("readback", rd, {16'h0000, rows[i][15:0]});
		end
		chk("range", {30'h0, rng}, 32'h3);
		chk("trim", {26'h0, trim}, 32'h0);
		repeat (3) @(posedge clk);
		chk("trigger", {31'h0, trigOut}, 32'h1);
		// pin A rising edge on one, pin B rising edge on two
		xfer(ADDR_CONTROL, 16'h8800, 1'b1);
		xfer(ADDR_EDGE_CONTROL, 16'hCCCC, 1'b1);
		pattern <= 6'h10;
		repeat (4) @(posedge clk);
		chk("one flag", {31'h0, csOn}, 32'h1);
		pattern <= 6'h30;
		repeat (4) @(posedge clk);
		chk("two flags", {31'h0, csOn}, 32'h0);
		xfer(ADDR_EDGE_CONTROL, 16'h0000, 1'b0);
		chk("flags", rd, 32'h0000CFCC);
		// channel two event before channel one is ignored
		xfer(ADDR_CONTROL, 16'h8C00, 1'b1);
		xfer(ADDR_EDGE_CONTROL, 16'hCCCC, 1'b1);
		pattern <= 6'h00;
		repeat (4) @(posedge clk);
		pattern <= 6'h20;
		repeat (4) @(posedge clk);
		xfer(ADDR_EDGE_CONTROL, 16'h0000, 1'b0);
		chk("order", rd, 32'h0000CCCC);
		// gate closed blocks channel one
		xfer(ADDR_CONTROL, 16'h8000, 1'b1);
		pattern <= 6'h30;
		repeat (4) @(posedge clk);
		xfer(ADDR_EDGE_CONTROL, 16'h0000, 1'b0);
		chk("gate", rd, 32'h0000CCCC);
		give_verdict;
	end
endmodule
`default_nettype wire
